//--- design/sled_driver.sv
`timescale 1ns/10ps
module sled_driver #(
  parameter bit DE_VARIANT = 1'b0,
  parameter bit DIE_BUILD = 1'b0,
  parameter int BUF_DEPTH = sled_pkg::SLED_BUF_DEPTH
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire sled_pkg::sled_pins_t pins_in,
  input wire logic ext_rstn_in,
  input wire logic latch_ready_in,
  output logic frame_ready_out,
  output sled_pkg::sled_frame_t seg_out
);
  import sled_pkg::*;

  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;

  initial
  begin
    if (BUF_DEPTH < 2 || (BUF_DEPTH & (BUF_DEPTH - 1)) != 0)
    begin
      $error("sled_driver: BUF_DEPTH must be a power of two, at least 2");
    end
    if (SLED_FRAME_BITS != SLED_NUM_SEG + 1 || SLED_START_POS != SLED_NUM_SEG)
    begin
      $error("sled_driver: frame must be one start bit plus the segment bits");
    end
    if (SLED_DE_SEG != SLED_NUM_SEG - 1)
    begin
      $error("sled_driver: the enable pin must replace the last segment");
    end
    // Each serial clock phase must outlast the synchroniser
    if (SLED_SCLK_MIN_CYC < 4)
    begin
      $error("sled_driver: system clock too slow for the serial clock");
    end
  end

  // Pin synchronisers; stage one feeds stage two only
  sled_pins_t pins_s1_q;
  sled_pins_t pins_s2_q;
  sled_pins_t pins_s3_q;
  logic ext_s1_q;
  logic ext_s2_q;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pins_s1_q <= SLED_PINS_RST;
      pins_s2_q <= SLED_PINS_RST;
    end
    else
    begin
      pins_s1_q <= pins_in;
      pins_s2_q <= pins_s1_q;
    end
  end

  // Previous synchronised level, for edge detection
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pins_s3_q <= SLED_PINS_RST;
    end
    else
    begin
      pins_s3_q <= pins_s2_q;
    end
  end

  // Die reset pin idles high
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ext_s1_q <= 1'b1;
      ext_s2_q <= 1'b1;
    end
    else
    begin
      ext_s1_q <= ext_rstn_in;
      ext_s2_q <= ext_s1_q;
    end
  end

  wire die_clear = DIE_BUILD & ~ext_s2_q;
  wire enabled = ~DE_VARIANT | ~pins_s2_q.de_n;
  wire sclk_rise = pins_s2_q.sclk & ~pins_s3_q.sclk;
  wire sclk_fall = ~pins_s2_q.sclk & pins_s3_q.sclk;
  wire shift_en = sclk_rise & enabled;
  wire sclk_low = sclk_fall & enabled;

  // Shift chain and frame sequencer
  sled_state_t state_q;
  sled_state_t state_d;
  logic [35:0] chain_q;
  logic [35:0] chain_d;
  logic push;
  logic buf_in_ready;
  sled_frame_t frame_word;

  wire [35:0] chain_shifted = {chain_q[34:0], pins_s2_q.sdata};
  wire frame_done = chain_q[SLED_START_POS - 1];

  always_comb
  begin
    state_d = state_q;
    chain_d = chain_q;
    push = 1'b0;
    unique case (state_q)
      SLED_SHIFT:
      begin
        if (shift_en)
        begin
          chain_d = chain_shifted;
          // Start bit about to reach the top ends the frame
          if (frame_done)
          begin
            state_d = SLED_HOLD;
          end
        end
      end
      SLED_HOLD:
      begin
        if (buf_in_ready)
        begin
          push = 1'b1;
          state_d = SLED_CLEAR;
        end
      end
      SLED_CLEAR:
      begin
        if (sclk_low)
        begin
          chain_d = SLED_CHAIN_RST;
          state_d = SLED_SHIFT;
        end
      end
      default:
      begin
        state_d = SLED_SHIFT;
        chain_d = SLED_CHAIN_RST;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q <= SLED_SHIFT;
    end
    else if (die_clear)
    begin
      state_q <= SLED_SHIFT;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      chain_q <= SLED_CHAIN_RST;
    end
    else if (die_clear)
    begin
      chain_q <= SLED_CHAIN_RST;
    end
    else
    begin
      chain_q <= chain_d;
    end
  end

  // Bit after the start bit sits just below it and maps to output 1
  for (genvar i = 0; i < SLED_NUM_SEG; i++)
  begin : g_map
    assign frame_word[i] = chain_q[SLED_START_POS - 1 - i];
  end

  // BUF_DEPTH-entry frame buffer (two by default) between chain and output latches
  sled_frame_t buf_q [BUF_DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] wr_ptr_d;
  logic [PW-1:0] rd_ptr_q;
  logic [PW-1:0] rd_ptr_d;
  logic [PW:0] count_q;
  logic [PW:0] count_d;
  logic [BUF_DEPTH-1:0] buf_we;

  wire buf_out_valid = (count_q != '0);
  wire pop = buf_out_valid & latch_ready_in;
  assign buf_in_ready = (count_q != (PW + 1)'(BUF_DEPTH));
  assign frame_ready_out = buf_in_ready;
  assign wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
  assign rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
  assign count_d = count_q + (PW + 1)'(push) - (PW + 1)'(pop);

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      wr_ptr_q <= '0;
    end
    else if (die_clear)
    begin
      wr_ptr_q <= '0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_d;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rd_ptr_q <= '0;
    end
    else if (die_clear)
    begin
      rd_ptr_q <= '0;
    end
    else
    begin
      rd_ptr_q <= rd_ptr_d;
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      count_q <= '0;
    end
    else if (die_clear)
    begin
      count_q <= '0;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  for (genvar e = 0; e < BUF_DEPTH; e++)
  begin : g_buf
    assign buf_we[e] = push && (wr_ptr_q == PW'(e));
    always_ff @(posedge clock_in or negedge rstn_in)
    begin
      if (!rstn_in)
      begin
        buf_q[e] <= SLED_SEG_RST;
      end
      else if (buf_we[e])
      begin
        buf_q[e] <= frame_word;
      end
    end
  end

  // Output latches hold until a buffered frame is taken
  sled_frame_t seg_q;
  sled_frame_t seg_d;
  sled_frame_t seg_mask;

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      seg_q <= SLED_SEG_RST;
    end
    else if (die_clear)
    begin
      seg_q <= SLED_SEG_RST;
    end
    else if (pop)
    begin
      seg_q <= seg_d;
    end
  end

  // Enable variant has no 35th output
  always_comb
  begin
    seg_mask = '1;
    seg_mask[SLED_DE_SEG] = ~DE_VARIANT;
  end

  assign seg_d = buf_q[rd_ptr_q] & seg_mask;

  assign seg_out = seg_q;

endmodule // sled_driver

//--- design/sled_pkg.sv
package sled_pkg;

  localparam int SLED_NUM_SEG = 35;
  localparam int SLED_FRAME_BITS = 36;
  localparam int SLED_START_POS = 35;
  localparam int SLED_DE_SEG = 34;
  localparam int SLED_BUF_DEPTH = 2;
  localparam int SLED_SCLK_MAX_KHZ = 500;
  localparam int SLED_CLK_KHZ = 10_000;
  localparam int SLED_SCLK_MIN_CYC = SLED_CLK_KHZ / SLED_SCLK_MAX_KHZ;
  localparam logic [35:0] SLED_CHAIN_RST = 36'h0;
  localparam logic [34:0] SLED_SEG_RST = 35'h0;

  typedef logic [34:0] sled_frame_t;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic de_n;
  } sled_pins_t;

  localparam sled_pins_t SLED_PINS_RST = '{sclk: 1'b0, sdata: 1'b0, de_n: 1'b1};

  typedef enum logic [2:0] {
    SLED_SHIFT = 3'b001,
    SLED_HOLD = 3'b010,
    SLED_CLEAR = 3'b100
  } sled_state_t;

endpackage

//--- verification/sled_driver_properties.sv
`timescale 1ns/10ps
module sled_driver_properties #(parameter bit DE_VARIANT = 1'b0) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire sled_pkg::sled_pins_t pins_in,
  input wire logic ext_rstn_in,
  input wire logic latch_ready_in,
  input wire logic frame_ready_out,
  input wire sled_pkg::sled_frame_t seg_out
);
  import sled_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  sequence s_low; (!pins_in.sclk && latch_ready_in)[*8]; endsequence
  sequence s_rdy; latch_ready_in[*6]; endsequence
  property p_rst; $rose(rstn_in) |-> seg_out == '0; endproperty
  a_rst: assert property (p_rst) else $error("seg reset");
  property p_rdy; $rose(rstn_in) |-> frame_ready_out; endproperty
  a_rdy: assert property (p_rdy) else $error("buf reset");
  property p_stall; !latch_ready_in |=> $stable(seg_out); endproperty
  a_stall: assert property (p_stall) else $error("stall");
  property p_fill; $fell(frame_ready_out) |-> !$past(latch_ready_in); endproperty
  a_fill: assert property (p_fill) else $error("fill");
  property p_drain; latch_ready_in[*3] |-> frame_ready_out; endproperty
  a_drain: assert property (p_drain) else $error("drain");
  property p_hold; s_low |-> $stable(seg_out); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_late; s_rdy ##0 $rose(pins_in.sclk) |=> $stable(seg_out)[*2]; endproperty
  a_late: assert property (p_late) else $error("early");
  property p_de; DE_VARIANT |-> !seg_out[SLED_DE_SEG]; endproperty
  a_de: assert property (p_de) else $error("enable");
endmodule // sled_driver_properties

//--- verification/sled_driver_test.sv
`timescale 1ns/10ps
module sled_driver_test;
  import sled_pkg::*;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic latch_ready_in = 1'b1;
  logic frame_ready_out;
  sled_pins_t pins;
  sled_frame_t seg_out, seg_prev, f;
  sled_frame_t exp_q[$];
  int num_errors = 0;
  int check_count = 0;
  sled_driver dut (.clock_in, .rstn_in, .pins_in(pins), .ext_rstn_in(1'b1), .latch_ready_in,
    .frame_ready_out, .seg_out);
  sled_host_model host (.clock_in, .pins_out(pins));
  initial
  begin
    forever #50 clock_in = ~clock_in;
  end
  task automatic compare(input logic [34:0] e, input logic [34:0] g);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("wrong value at %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic frame(input sled_frame_t d);
    exp_q.push_back(d);
    host.send({d, 1'b1}, 36);
  endtask
  // Any unexpected change fails
  always @(negedge clock_in)
  begin
    if (rstn_in && seg_out !== seg_prev)
      compare(exp_q.size() ? exp_q.pop_front() : ~seg_out, seg_out);
    seg_prev = seg_out;
  end
  initial
  begin
    void'($urandom(32'h7BE1));
    repeat (5) @(negedge clock_in);
    rstn_in = 1'b1;
    compare('0, seg_out);
    frame(35'h1);
    frame(35'h4_0000_0000);
    repeat (3)
      frame(35'({$urandom, $urandom}));
    $display("test frames done");
    f = 35'($urandom);
    exp_q.push_back(f);
    host.send({f, 1'b1}, 20);
    repeat (60) @(negedge clock_in);
    host.send(36'({f, 1'b1} >> 20), 16);
    $display("test split done");
    latch_ready_in = 1'b0;
    frame('1);
    frame(35'h5_5555_5555);
    compare('0, 35'(frame_ready_out));
    latch_ready_in = 1'b1;
    $display("test stall done");
    host.send('1, 18);
    rstn_in = 1'b0;
    repeat (5) @(negedge clock_in);
    compare('0, seg_out);
    rstn_in = 1'b1;
    frame(35'h7_0F0F_0F0F);
    repeat (10) @(negedge clock_in);
    compare('0, 35'(exp_q.size()));
    $display("test reset done");
    end_of_test();
  end
  initial
  begin
    #3_000_000;
    num_errors++;
    end_of_test();
  end
endmodule // sled_driver_test
bind sled_driver sled_driver_properties #(.DE_VARIANT(DE_VARIANT)) chk (.clock_in, .rstn_in,
  .pins_in, .ext_rstn_in, .latch_ready_in, .frame_ready_out, .seg_out);

//--- verification/sled_host_model.sv
`timescale 1ns/10ps
module sled_host_model (
  input wire logic clock_in,
  output sled_pkg::sled_pins_t pins_out
);
  import sled_pkg::*;
  initial pins_out = '{sclk: 1'b0, sdata: 1'b0, de_n: 1'b0};
  // LSB first, ten clocks each phase
  task automatic send(input logic [35:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      repeat (5) @(negedge clock_in);
      pins_out.sdata = bits[i];
      repeat (5) @(negedge clock_in);
      pins_out.sclk = 1'b1;
      repeat (10) @(negedge clock_in);
      pins_out.sclk = 1'b0;
    end
    repeat (3) @(negedge clock_in);
    pins_out.sdata = ~pins_out.sdata;
  endtask
endmodule // sled_host_model
